// >>> pkg/tsam_pkg.sv
package tsam_pkg;

   // ****************************************
   // register bus
   // ****************************************
   localparam int             WB_AW       = 8;
   localparam logic [WB_AW-1:0] ADDR_CTRL   = 8'h00;
   localparam logic [WB_AW-1:0] ADDR_STATUS = 8'h04;
   localparam logic [WB_AW-1:0] ADDR_PERF   = 8'h08;

   // ****************************************
   // service types and line codes
   // ****************************************
   localparam logic [1:0] SVC_DS1   = 2'h0;
   localparam logic [1:0] SVC_E1    = 2'h1;
   localparam logic [1:0] SVC_J2    = 2'h2;
   localparam logic [1:0] LC_B8ZS   = 2'h0;
   localparam logic [1:0] LC_AMI    = 2'h1;
   localparam logic [1:0] LC_HDB3   = 2'h2;

   // control register layout, reserved bits held at zero
   typedef struct packed {
      logic [11:0] rsvd_hi;
      logic [3:0]  sig_code;
      logic [7:0]  idle_code;
      logic [2:0]  rsvd_lo;
      logic        ami;
      logic        cas;
      logic        extended_superframe;
      logic [1:0]  svc;
   } tsam_ctrl_t;

   localparam tsam_ctrl_t CTRL_RST = 32'h0009_7f04;

   // ****************************************
   // line indication pins, index into the synchroniser
   // ****************************************
   localparam int NPIN        = 5;
   localparam int PIN_NOPULSE = 0;
   localparam int PIN_ONES    = 1;
   localparam int PIN_FRAME   = 2;
   localparam int PIN_MFRAME  = 3;
   localparam int PIN_YELLOW  = 4;
   localparam int CNT_W       = 8;

   // ****************************************
   // data link and bit-oriented messages
   // ****************************************
   localparam logic [7:0] FDL_LM_TAG    = 8'h01;
   localparam logic [1:0] FDL_BODY_LAST = 2'h2;
   localparam logic [7:0] PERF_CNT_ONE  = 8'h01;
   localparam logic [5:0] BOM_YELLOW    = 6'h00;
   localparam logic [5:0] BOM_LOOP_UP   = 6'h07;
   localparam logic [5:0] BOM_LOOP_DOWN = 6'h1c;

   typedef enum logic [1:0] {FDL_HUNT, FDL_BODY, FDL_SKIP} tsam_fdl_st_t;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       valid;
      logic       rb_frame;
      logic [3:0] sig;
      logic [7:0] data;
   } tsam_ts_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] octet;
   } tsam_fdl_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] code;
   } tsam_bom_t;

   typedef struct packed {
      logic signal_loss;
      logic all_ones_alarm_indication;
      logic rai_rx;
      logic lof;
      logic lomf;
   } tsam_alarm_t;

   typedef struct packed {
      logic [NPIN-1:0]  sy1;
      logic [NPIN-1:0]  sy2;
      logic [NPIN-1:0]  sy3;
      logic [NPIN-1:0]  filt;
      logic [CNT_W-1:0] los_cnt;
      logic [CNT_W-1:0] ais_cnt;
      tsam_alarm_t      alm;
      logic             bom_yellow;
      logic             loop_req;
      logic             trunk;
      logic             tx_rai;
      logic [1:0]       line_code;
      tsam_ctrl_t       ctrl;
      tsam_fdl_st_t     fdl_st;
      logic [1:0]       fdl_idx;
      logic [23:0]      fdl_buf;
      logic [31:0]      perf;
      tsam_ts_t         seg;
      logic             wb_ack;
      logic [31:0]      wb_dat;
   } tsam_state_t;

endpackage

// >>> src/tsam_top.sv
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tsam_top #(
   parameter logic [tsam_pkg::CNT_W-1:0] LOS_DET_CYC = 8'h20,
   parameter logic [tsam_pkg::CNT_W-1:0] AIS_DET_CYC = 8'h20
) (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          rstn,
   // wishbone slave
   input  wire logic                          wb_cyc,
   input  wire logic                          wb_stb,
   input  wire logic                          wb_we,
   input  wire logic [tsam_pkg::WB_AW-1:0]    wb_adr,
   input  wire logic [3:0]                    wb_sel,
   input  wire logic [31:0]                   wb_dat_w,
   output logic      [31:0]                   wb_dat_r,
   output logic                               wb_ack,
   // line receiver indications, asynchronous
   input  wire logic [tsam_pkg::NPIN-1:0]     line_ind,
   // received timeslot stream and messages
   input  wire tsam_pkg::tsam_ts_t            ts_in,
   input  wire tsam_pkg::tsam_fdl_t           fdl_in,
   input  wire tsam_pkg::tsam_bom_t           bom_in,
   // toward segmentation
   output tsam_pkg::tsam_ts_t                 seg_out,
   // maintenance outputs
   output tsam_pkg::tsam_alarm_t              alarm_out,
   output logic                               trunk_cond,
   output logic                               tx_rai,
   output logic      [1:0]                    line_code,
   output logic                               loop_req
);

   tsam_pkg::tsam_state_t s_reg;
   tsam_pkg::tsam_state_t s_next;

   logic is_e1;
   logic is_j2;
   logic is_ds1;
   logic ds1_esf;
   logic fdl_on;
   logic mf_used;

   assign is_e1   = (s_reg.ctrl.svc == tsam_pkg::SVC_E1);
   assign is_j2   = (s_reg.ctrl.svc == tsam_pkg::SVC_J2);
   // the unused service code behaves as DS1
   assign is_ds1  = !is_e1 && !is_j2;
   assign ds1_esf = is_ds1 && s_reg.ctrl.extended_superframe;
   assign fdl_on  = ds1_esf || is_j2;
   assign mf_used = ds1_esf || s_reg.ctrl.cas;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      s_next = s_reg;

      // three-stage synchroniser, level accepted once stages two and three agree
      s_next.sy1  = line_ind;
      s_next.sy2  = s_reg.sy1;
      s_next.sy3  = s_reg.sy2;
      // stages disagree: hold the last accepted level, so a glitch never counts
      s_next.filt = (s_reg.sy2 & s_reg.sy3) | (s_reg.filt & (s_reg.sy2 ^ s_reg.sy3));

      // persistence counters; a single dropout restarts detection
      if (s_reg.filt[tsam_pkg::PIN_NOPULSE])
      begin
         if (s_reg.los_cnt != LOS_DET_CYC)
         begin
            s_next.los_cnt = s_reg.los_cnt + 8'h01;
         end
      end
      else
      begin
         s_next.los_cnt = '0;
      end
      if (s_reg.filt[tsam_pkg::PIN_ONES])
      begin
         if (s_reg.ais_cnt != AIS_DET_CYC)
         begin
            s_next.ais_cnt = s_reg.ais_cnt + 8'h01;
         end
      end
      else
      begin
         s_next.ais_cnt = '0;
      end

      // alarm levels follow the condition both ways
      s_next.alm.signal_loss    = (s_next.los_cnt == LOS_DET_CYC);
      s_next.alm.all_ones_alarm_indication    = (s_next.ais_cnt == AIS_DET_CYC);
      s_next.alm.lof    = !s_reg.filt[tsam_pkg::PIN_FRAME];
      s_next.alm.lomf   = mf_used && !s_reg.filt[tsam_pkg::PIN_MFRAME];
      s_next.alm.rai_rx = s_reg.filt[tsam_pkg::PIN_YELLOW] || s_reg.bom_yellow;

      s_next.trunk  = s_next.alm.signal_loss || s_next.alm.all_ones_alarm_indication || s_next.alm.lof
                      || s_next.alm.rai_rx;
      s_next.tx_rai = s_next.alm.signal_loss || s_next.alm.all_ones_alarm_indication || s_next.alm.lof;

      // line coding per service type
      if (is_e1)
      begin
         s_next.line_code = tsam_pkg::LC_HDB3;
      end
      else if (is_j2)
      begin
         s_next.line_code = tsam_pkg::LC_B8ZS;
      end
      else
      begin
         s_next.line_code = s_reg.ctrl.ami ? tsam_pkg::LC_AMI : tsam_pkg::LC_B8ZS;
      end

      // timeslot path: one octet out per octet in, never throttled
      s_next.seg.valid    = ts_in.valid;
      s_next.seg.rb_frame = ts_in.rb_frame;
      s_next.seg.data     = ts_in.data;
      s_next.seg.sig      = '0;
      if (s_reg.ctrl.cas)
      begin
         s_next.seg.sig = ts_in.sig;
         if (is_ds1 && ts_in.rb_frame)
         begin
            s_next.seg.sig[0] = ts_in.data[0];
         end
      end
      if (s_reg.trunk)
      begin
         s_next.seg.data = s_reg.ctrl.idle_code;
         if (s_reg.ctrl.cas)
         begin
            s_next.seg.sig = s_reg.ctrl.sig_code;
            if (is_ds1 && ts_in.rb_frame)
            begin
               s_next.seg.data[0] = s_reg.ctrl.sig_code[0];
            end
         end
      end

      // data link: tag octet then three count octets, ended by last
      if (!fdl_on)
      begin
         s_next.fdl_st  = tsam_pkg::FDL_HUNT;
         s_next.fdl_idx = '0;
      end
      else if (fdl_in.valid)
      begin
         case (s_reg.fdl_st)
            tsam_pkg::FDL_HUNT:
            begin
               s_next.fdl_idx = '0;
               if (!fdl_in.last && fdl_in.octet == tsam_pkg::FDL_LM_TAG)
               begin
                  s_next.fdl_st = tsam_pkg::FDL_BODY;
               end
               else if (!fdl_in.last)
               begin
                  s_next.fdl_st = tsam_pkg::FDL_SKIP;
               end
            end
            tsam_pkg::FDL_BODY:
            begin
               s_next.fdl_buf = {s_reg.fdl_buf[15:0], fdl_in.octet};
               if (fdl_in.last)
               begin
                  s_next.fdl_st = tsam_pkg::FDL_HUNT;
                  if (s_reg.fdl_idx == tsam_pkg::FDL_BODY_LAST)
                  begin
                     s_next.perf = {s_reg.perf[31:24] + tsam_pkg::PERF_CNT_ONE,
                                    s_next.fdl_buf};
                  end
               end
               else if (s_reg.fdl_idx == tsam_pkg::FDL_BODY_LAST)
               begin
                  s_next.fdl_st = tsam_pkg::FDL_SKIP;
               end
               else
               begin
                  s_next.fdl_idx = s_reg.fdl_idx + 2'h1;
               end
            end
            tsam_pkg::FDL_SKIP:
            begin
               if (fdl_in.last)
               begin
                  s_next.fdl_st = tsam_pkg::FDL_HUNT;
               end
            end
            default:
            begin
               s_next.fdl_st = tsam_pkg::FDL_HUNT;
            end
         endcase
      end

      // bit-oriented messages, DS1 extended superframe only
      if (!ds1_esf)
      begin
         s_next.bom_yellow = 1'b0;
         s_next.loop_req   = 1'b0;
      end
      else if (bom_in.valid)
      begin
         s_next.bom_yellow = (bom_in.code == tsam_pkg::BOM_YELLOW);
         if (bom_in.code == tsam_pkg::BOM_LOOP_UP)
         begin
            s_next.loop_req = 1'b1;
         end
         else if (bom_in.code == tsam_pkg::BOM_LOOP_DOWN)
         begin
            s_next.loop_req = 1'b0;
         end
      end

      // wishbone: answer one cycle after the strobe, drop the cycle after
      s_next.wb_ack = wb_cyc && wb_stb && !s_reg.wb_ack;
      s_next.wb_dat = '0;
      if (wb_cyc && wb_stb && !s_reg.wb_ack)
      begin
         if (wb_we && wb_adr == tsam_pkg::ADDR_CTRL)
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (wb_sel[i])
               begin
                  s_next.ctrl[i*8 +: 8] = wb_dat_w[i*8 +: 8];
               end
            end
            s_next.ctrl.rsvd_hi = '0;
            s_next.ctrl.rsvd_lo = '0;
         end
         else if (!wb_we)
         begin
            case (wb_adr)
               tsam_pkg::ADDR_CTRL:
               begin
                  s_next.wb_dat = s_reg.ctrl;
               end
               tsam_pkg::ADDR_STATUS:
               begin
                  s_next.wb_dat = {20'h0_0000, s_reg.line_code, fdl_on, s_reg.loop_req,
                                   s_reg.bom_yellow, s_reg.tx_rai, s_reg.trunk,
                                   s_reg.alm.lomf, s_reg.alm.lof, s_reg.alm.rai_rx,
                                   s_reg.alm.all_ones_alarm_indication, s_reg.alm.signal_loss};
               end
               tsam_pkg::ADDR_PERF:
               begin
                  s_next.wb_dat = s_reg.perf;
               end
               default:
               begin
                  s_next.wb_dat = '0;
               end
            endcase
         end
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_reg      <= '0;
         s_reg.ctrl <= tsam_pkg::CTRL_RST;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_r   = s_reg.wb_dat;
   assign wb_ack     = s_reg.wb_ack;
   assign seg_out    = s_reg.seg;
   assign alarm_out  = s_reg.alm;
   assign trunk_cond = s_reg.trunk;
   assign tx_rai     = s_reg.tx_rai;
   assign line_code  = s_reg.line_code;
   assign loop_req   = s_reg.loop_req;

   // ****************************************
   // checks
   // ****************************************
   a_fault_sends_yellow: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_reg.alm.signal_loss || s_reg.alm.all_ones_alarm_indication || s_reg.alm.lof) |-> (s_reg.tx_rai && s_reg.trunk))
      else $error("line fault without yellow and conditioning");

   a_yellow_no_return: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_reg.alm.rai_rx && !s_reg.alm.signal_loss && !s_reg.alm.all_ones_alarm_indication && !s_reg.alm.lof)
      |-> (s_reg.trunk && !s_reg.tx_rai))
      else $error("received yellow handled wrongly");

   a_rate_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
      ts_in.valid |=> seg_out.valid)
      else $error("octet dropped toward segmentation");

   a_idle_payload: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_reg.trunk && !s_reg.ctrl.cas && ts_in.valid)
      |=> (seg_out.data == $past(s_reg.ctrl.idle_code)))
      else $error("payload not replaced by idle code");

   a_cond_signalling: assert property (@(posedge sys_clk) disable iff (!rstn)
      (s_reg.trunk && s_reg.ctrl.cas && ts_in.valid)
      |=> (seg_out.sig == $past(s_reg.ctrl.sig_code)))
      else $error("signalling code not inserted");

   a_basic_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!s_reg.trunk && !s_reg.ctrl.cas && ts_in.valid)
      |=> (seg_out.data == $past(ts_in.data) && seg_out.sig == 4'h0))
      else $error("basic mode altered the timeslot");

   a_link_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
      !fdl_on |=> $stable(s_reg.perf))
      else $error("data link processed for wrong service");

   a_bom_gated: assert property (@(posedge sys_clk) disable iff (!rstn)
      !ds1_esf |=> (!s_reg.loop_req && !s_reg.bom_yellow))
      else $error("bit message acted on outside DS1 superframe");

   a_e1_hdb3: assert property (@(posedge sys_clk) disable iff (!rstn)
      (is_e1 && $stable(s_reg.ctrl)) |=> (line_code == tsam_pkg::LC_HDB3))
      else $error("E1 not on HDB3");

   a_j2_b8zs: assert property (@(posedge sys_clk) disable iff (!rstn)
      (is_j2 && $stable(s_reg.ctrl)) |=> (line_code == tsam_pkg::LC_B8ZS))
      else $error("J2 not on B8ZS");

   a_ds1_code: assert property (@(posedge sys_clk) disable iff (!rstn)
      (is_ds1 && $stable(s_reg.ctrl))
      |=> (line_code == ($past(s_reg.ctrl.ami) ? tsam_pkg::LC_AMI : tsam_pkg::LC_B8ZS)))
      else $error("DS1 line code wrong");

   a_loss_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
      !s_reg.filt[tsam_pkg::PIN_NOPULSE] |=> !s_reg.alm.signal_loss)
      else $error("signal loss stayed after pulses returned");

   a_report_stored: assert property (@(posedge sys_clk) disable iff (!rstn)
      (fdl_on && fdl_in.valid && fdl_in.last && s_reg.fdl_st == tsam_pkg::FDL_BODY
       && s_reg.fdl_idx == tsam_pkg::FDL_BODY_LAST)
      |=> (s_reg.perf[7:0] == $past(fdl_in.octet)
           && s_reg.perf[31:24] == $past(s_reg.perf[31:24]) + 8'h01))
      else $error("performance report not stored");

endmodule

`default_nettype wire

// >>> test/tsam_line_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// line terminal model
// ****************
module tsam_line_model (
   // clock and reset
   input  wire logic           sys_clk,
   input  wire logic           rstn,
   // commands from the bench
   input  wire logic [4:0]     line_state,
   input  wire logic           fdl_go,
   input  wire logic [39:0]    fdl_msg,
   input  wire logic [2:0]     fdl_len,
   input  wire logic           bom_go,
   input  wire logic [5:0]     bom_code,
   // toward the block
   output logic [4:0]          line_ind,
   output tsam_pkg::tsam_ts_t  ts_in,
   output tsam_pkg::tsam_fdl_t fdl_in,
   output tsam_pkg::tsam_bom_t bom_in,
   output logic                fdl_busy
);
   logic [15:0] cnt;
   logic [39:0] sh;
   logic [2:0]  left;

   // pins move on the falling edge, so the block sees them unaligned
   initial line_ind = 5'h00;
   always @(negedge sys_clk) line_ind <= line_state;

   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
      begin
         cnt    <= 16'h0;
         left   <= 3'h0;
         ts_in  <= '0;
         fdl_in <= '0;
         bom_in <= '0;
      end
      else
      begin
         cnt            <= cnt + 16'h1;
         ts_in.valid    <= cnt[3:0] != 4'hf;
         ts_in.rb_frame <= cnt[2:0] == 3'h5;
         ts_in.sig      <= cnt[7:4];
         ts_in.data     <= cnt[15:8] ^ cnt[7:0];
         bom_in.valid   <= bom_go;
         // idle lines toggle so a stale value is never mistaken for data
         bom_in.code    <= bom_go ? bom_code : ~bom_in.code;
         fdl_in.valid   <= 1'b0;
         fdl_in.last    <= 1'b0;
         fdl_in.octet   <= ~fdl_in.octet;
         if (fdl_go)
         begin
            sh   <= fdl_msg;
            left <= fdl_len;
         end
         else if (left != 3'h0)
         begin
            fdl_in.valid <= 1'b1;
            fdl_in.last  <= left == 3'h1;
            fdl_in.octet <= sh[8*left-1 -: 8];
            left         <= left - 3'h1;
         end
      end

   assign fdl_busy = left != 3'h0 || fdl_in.valid;
endmodule

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [4:0]  pins;
      logic [4:0]  alm;
      logic        tc;
      logic        remote_alarm_indication;
      logic [1:0]  lc;
   } tsam_row_t;

   // ****************
   // signals
   // ****************
   logic                  sys_clk = 1'b0, rstn = 1'b0;
   logic                  wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0]            wb_adr = 8'h00;
   logic [3:0]            wb_sel = 4'hf;
   logic [31:0]           wb_dat_w = 32'h0, wb_dat_r, rd;
   logic                  wb_ack, trunk_cond, tx_rai, loop_req, fdl_busy;
   logic [4:0]            line_ind, line_state = 5'h0c;
   logic [1:0]            line_code;
   tsam_pkg::tsam_ts_t    ts_in, seg_out, prev_ts, e;
   tsam_pkg::tsam_fdl_t   fdl_in;
   tsam_pkg::tsam_bom_t   bom_in;
   tsam_pkg::tsam_alarm_t alarm_out;
   tsam_pkg::tsam_ctrl_t  ctrl_sh;
   logic                  fdl_go = 1'b0, bom_go = 1'b0, seg_en = 1'b0, prev_tc, rb;
   logic [39:0]           fdl_msg = 40'h0;
   logic [2:0]            fdl_len = 3'h0;
   logic [5:0]            bom_code = 6'h00;
   int                    fail_count = 0, num_checks = 0, cyc_cnt = 0;

   tsam_row_t rows [13] = '{
      '{32'h0009_7f04, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h0},
      '{32'h0009_7f04, 5'h0d, 5'h10, 1'b1, 1'b1, 2'h0},
      '{32'h0009_7f04, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h0},
      '{32'h0009_7f04, 5'h0e, 5'h08, 1'b1, 1'b1, 2'h0},
      '{32'h0009_7f04, 5'h08, 5'h02, 1'b1, 1'b1, 2'h0},
      '{32'h0009_7f04, 5'h04, 5'h01, 1'b0, 1'b0, 2'h0},
      '{32'h0009_7f04, 5'h1c, 5'h04, 1'b1, 1'b0, 2'h0},
      '{32'h000a_d50c, 5'h0d, 5'h10, 1'b1, 1'b1, 2'h0},
      '{32'h000a_d50c, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h0},
      '{32'h0009_7f14, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h1},
      '{32'h0009_7f11, 5'h04, 5'h00, 1'b0, 1'b0, 2'h2},
      '{32'h0009_7f12, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h0},
      '{32'h0009_7f17, 5'h0c, 5'h00, 1'b0, 1'b0, 2'h1}};

   always #5 sys_clk = ~sys_clk;

   tsam_top #(.LOS_DET_CYC(8'h04), .AIS_DET_CYC(8'h04)) i_tsam_top (
      .sys_clk(sys_clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .line_ind(line_ind), .ts_in(ts_in),
      .fdl_in(fdl_in), .bom_in(bom_in), .seg_out(seg_out), .alarm_out(alarm_out),
      .trunk_cond(trunk_cond), .tx_rai(tx_rai), .line_code(line_code),
      .loop_req(loop_req));

   tsam_line_model i_tsam_line_model (
      .sys_clk(sys_clk), .rstn(rstn), .line_state(line_state), .fdl_go(fdl_go),
      .fdl_msg(fdl_msg), .fdl_len(fdl_len), .bom_go(bom_go), .bom_code(bom_code),
      .line_ind(line_ind), .ts_in(ts_in), .fdl_in(fdl_in), .bom_in(bom_in),
      .fdl_busy(fdl_busy));

   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_dat_w <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      rd = wb_dat_r;
      if (wb_ack !== 1'b1)
         chk(32'h0, 32'h1, "bus answer");
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (we && adr == tsam_pkg::ADDR_CTRL)
         ctrl_sh = d & 32'h000f_ff1f;
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
      wb(1'b0, adr, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic facility_data_link(input logic [39:0] m, input logic [2:0] len);
      int n;
      n = 0;
      @(posedge sys_clk);
      fdl_msg <= m;
      fdl_len <= len;
      fdl_go  <= 1'b1;
      @(posedge sys_clk);
      fdl_go <= 1'b0;
      @(posedge sys_clk);
      while (fdl_busy && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (fdl_busy)
         chk(32'h0, 32'h1, "link model stuck");
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic bom(input logic [5:0] c);
      @(posedge sys_clk);
      bom_code <= c;
      bom_go   <= 1'b1;
      @(posedge sys_clk);
      bom_go <= 1'b0;
      repeat (5) @(posedge sys_clk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ****************
   // stream monitor and watchdog
   // ****************
   always @(posedge sys_clk)
   begin
      prev_ts <= ts_in;
      prev_tc <= trunk_cond;
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   // conditioning follows the trunk level seen when the octet was taken
   always @(posedge sys_clk)
      if (seg_en)
      begin
         #1;
         e = prev_ts;
         rb = ctrl_sh.cas && prev_ts.rb_frame && ctrl_sh.svc != tsam_pkg::SVC_E1
              && ctrl_sh.svc != tsam_pkg::SVC_J2;
         e.sig = ctrl_sh.cas ? prev_ts.sig : 4'h0;
         if (rb)
            e.sig[0] = prev_ts.data[0];
         if (prev_tc)
         begin
            e.data = ctrl_sh.idle_code;
            if (ctrl_sh.cas)
               e.sig = ctrl_sh.sig_code;
            if (rb)
               e.data[0] = ctrl_sh.sig_code[0];
         end
         chk(32'(seg_out.valid), 32'(e.valid), "seg valid");
         if (e.valid)
            chk(32'(seg_out), 32'(e), "seg octet");
      end

   // ****************
   // sequence
   // ****************
   initial
   begin
      ctrl_sh = tsam_pkg::CTRL_RST;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         if (rows[i].ctrl !== ctrl_sh)
            wb(1'b1, tsam_pkg::ADDR_CTRL, rows[i].ctrl);
         line_state <= rows[i].pins;
         repeat (10) @(posedge sys_clk);
         seg_en <= 1'b1;
         repeat (12) @(posedge sys_clk);
         seg_en <= 1'b0;
         chk(32'(alarm_out), 32'(rows[i].alm), "alarms");
         chk(32'(trunk_cond), 32'(rows[i].tc), "trunk");
         chk(32'(tx_rai), 32'(rows[i].remote_alarm_indication), "yellow out");
         chk(32'(line_code), 32'(rows[i].lc), "line code");
      end
      $display("test rows done");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f04);
      facility_data_link(40'h01_05_06_07, 3'h4);
      rdchk(tsam_pkg::ADDR_PERF, 32'h0105_0607, "report");
      wb(1'b1, tsam_pkg::ADDR_PERF, 32'hffff_ffff);
      facility_data_link(40'h02_aa_bb_cc, 3'h4);
      facility_data_link(40'h01_11_22_33_44, 3'h5);
      rdchk(tsam_pkg::ADDR_PERF, 32'h0105_0607, "foreign message");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f05);
      facility_data_link(40'h01_0a_0b_0c, 3'h4);
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f00);
      facility_data_link(40'h01_0a_0b_0c, 3'h4);
      rdchk(tsam_pkg::ADDR_PERF, 32'h0105_0607, "link off");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f06);
      facility_data_link(40'h01_0d_0e_0f, 3'h4);
      rdchk(tsam_pkg::ADDR_PERF, 32'h020d_0e0f, "j2 report");
      $display("test data link done");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f04);
      bom(6'h07);
      chk(32'(loop_req), 32'h1, "loop up");
      bom(6'h00);
      chk(32'({alarm_out.rai_rx, trunk_cond, tx_rai}), 32'h6, "bit yellow");
      rdchk(tsam_pkg::ADDR_STATUS, 32'h0000_03a4, "status");
      bom(6'h1c);
      chk(32'({loop_req, alarm_out.rai_rx}), 32'h0, "loop down");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'h0009_7f05);
      bom(6'h07);
      chk(32'(loop_req), 32'h0, "bit message off");
      $display("test bit messages done");
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'hffff_ffff);
      rdchk(tsam_pkg::ADDR_CTRL, 32'h000f_ff1f, "reserved bits");
      rdchk(8'h0c, 32'h0, "unmapped");
      wb_sel <= 4'h2;
      wb(1'b1, tsam_pkg::ADDR_CTRL, 32'hffff_3cff);
      wb_sel <= 4'hf;
      rdchk(tsam_pkg::ADDR_CTRL, 32'h000f_3c1f, "byte lanes");
      $display("test registers done");
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(32'({alarm_out, trunk_cond, tx_rai, line_code, loop_req, wb_ack}), 32'h0, "in reset");
      rstn <= 1'b1;
      ctrl_sh = tsam_pkg::CTRL_RST;
      rdchk(tsam_pkg::ADDR_CTRL, 32'(tsam_pkg::CTRL_RST), "ctrl reset");
      repeat (20) @(posedge sys_clk);
      chk(32'({trunk_cond, alarm_out}), 32'h0, "after reset");
      $display("test reset done");
      report_and_stop();
   end
endmodule

`default_nettype wire
